//--- hw/rsx_pkg.sv
`default_nettype none

package rsx_pkg;

    // Instruction encodings, 14 bits wide.
    localparam logic [13:0] OP_ROTATE_LEFT = 14'h0d00;
    localparam logic [13:0] OP_ROTATE_MASK = 14'h3f00;
    localparam logic [13:0] OP_HALT = 14'h0063;
    localparam int DEST_BIT_POS = 7;

    // Register offsets, byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_WORK = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_FILE_BASE = 8'h80;

    // Status field positions.
    localparam int ST_CARRY_POS = 0;
    localparam int ST_PD_POS = 1;
    localparam int ST_TO_POS = 2;
    localparam int ST_HALT_POS = 3;

    // Values after reset.
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam logic [7:0] PRESC_RESET = 8'h00;

    // Number of file registers.
    localparam int FILE_DEPTH = 32;

    // One instruction request.
    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } rsx_instr_s;

    // Result of the rotate unit.
    typedef struct packed {
        logic [7:0] value;
        logic carry;
    } rsx_rot_s;

    typedef enum logic [1:0] {
        RSX_RUN = 2'b00,
        RSX_HALT = 2'b01
    } rsx_state_e;

endpackage

`default_nettype wire

//--- hw/rsx_rotate.sv
`timescale 1ns/1ps
`default_nettype none

module rsx_rotate (
    // Operand.
    input wire logic [7:0] operand,
    input wire logic carry_in,
    // Result.
    output rsx_pkg::rsx_rot_s result
);

    // Bit 7 leaves into carry, old carry enters bit 0.
    always_comb begin
        result.value = {operand[6:0], carry_in}; // see (RULE_01) see (RULE_04)
        result.carry = operand[7]; // see (RULE_04)
    end

endmodule

`default_nettype wire

//--- hw/rsx_core.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE_01) The rotate instruction shifts the addressed file register left by one bit through carry.
// (RULE_02) With the destination bit at 0 the result goes to the working register and the file is untouched.
// (RULE_03) With the destination bit at 1 the result is written back to the addressed file register.
// (RULE_04) The old carry enters bit 0 and the old bit 7 becomes the new carry.
// (RULE_05) The halt instruction clears the power-down flag.
// (RULE_06) The halt instruction sets the time-out flag.
// (RULE_07) The halt instruction clears the watchdog counter and its prescaler.
// (RULE_08) After halt the core stops executing until a wake-up.
module rsx_core (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Halt state and wake-up.
    input wire logic WAKE,
    output logic HALTED,
    output logic OSC_RUN
);

    // Bus address phase capture.
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // Core state.
    logic [7:0] work_r, work_nxt;
    logic carry_r, carry_nxt;
    logic power_down_flag_r, power_down_flag_nxt;
    logic timeout_flag_r, timeout_flag_nxt;
    logic [7:0] watchdog_counter_r, watchdog_counter_nxt;
    logic [7:0] presc_r, presc_nxt;
    logic wdt_run_r, wdt_run_nxt;
    rsx_pkg::rsx_state_e state_r, state_nxt;
    logic [7:0] file_r [rsx_pkg::FILE_DEPTH];
    logic file_we;
    logic [4:0] file_wa;
    logic [7:0] file_wd;
    logic wake_s1_r, wake_s2_r;

    rsx_pkg::rsx_instr_s instr;
    rsx_pkg::rsx_rot_s rot;
    logic [4:0] faddr;
    logic is_rot, is_halt;

    // True when an address points into the file register window.
    // The upper bound is worked out in nine bits, since the window reaches the top of the 8-bit map.
    function automatic logic in_file(input logic [7:0] a);
        in_file = (a >= rsx_pkg::REG_FILE_BASE) &&
                  (9'(a) < 9'(rsx_pkg::REG_FILE_BASE) + 9'(4 * rsx_pkg::FILE_DEPTH));
    endfunction

    // File index taken from a byte address.
    function automatic logic [4:0] file_idx(input logic [7:0] a);
        file_idx = a[6:2];
    endfunction

    // The wake pin comes from outside, so it passes two flops first.
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= WAKE;
            wake_s2_r <= wake_s1_r;
        end
    end

    // An instruction is a bus write to the instruction register.
    always_comb begin
        instr.valid = wr_pend_r && (addr_r == rsx_pkg::REG_INSTR);
        instr.word = HWDATA[13:0];
        faddr = HWDATA[4:0];
        is_rot = instr.valid && ((instr.word & rsx_pkg::OP_ROTATE_MASK) == rsx_pkg::OP_ROTATE_LEFT);
        is_halt = instr.valid && (instr.word == rsx_pkg::OP_HALT);
    end

    // Rotate unit works on the addressed file register and the current carry.
    rsx_rotate u_rot ( // see (RULE_01)
        .operand(file_r[faddr]),
        .carry_in(carry_r),
        .result(rot)
    );

    // Next-state logic for bus, core flags and the watchdog.
    always_comb begin
        wr_pend_nxt = HSEL && HREADY && HTRANS[1] && HWRITE;
        addr_nxt = (HSEL && HREADY && HTRANS[1]) ? HADDR[7:0] : addr_r;
        rdata_nxt = rdata_r;
        work_nxt = work_r;
        carry_nxt = carry_r;
        power_down_flag_nxt = power_down_flag_r;
        timeout_flag_nxt = timeout_flag_r;
        watchdog_counter_nxt = watchdog_counter_r;
        presc_nxt = presc_r;
        wdt_run_nxt = wdt_run_r;
        state_nxt = state_r;
        file_we = 1'b0;
        file_wa = faddr;
        file_wd = rot.value;
        // Watchdog keeps counting even while halted; only the synchronised WAKE pin wakes a sleeping core.
        if (wdt_run_r) begin
            presc_nxt = presc_r + 8'h01;
            if (presc_r == 8'hff) begin
                watchdog_counter_nxt = watchdog_counter_r + 8'h01;
            end
        end
        if (state_r == rsx_pkg::RSX_RUN) begin
            // Instructions are refused while halted, so nothing executes until wake-up.
            if (is_rot) begin
                carry_nxt = rot.carry; // see (RULE_04)
                if (instr.word[rsx_pkg::DEST_BIT_POS]) begin
                    file_we = 1'b1; // see (RULE_03)
                end else begin
                    work_nxt = rot.value; // see (RULE_02)
                end
            end else if (is_halt) begin
                power_down_flag_nxt = 1'b0; // see (RULE_05)
                timeout_flag_nxt = 1'b1; // see (RULE_06)
                watchdog_counter_nxt = rsx_pkg::WDT_RESET; // see (RULE_07)
                presc_nxt = rsx_pkg::PRESC_RESET; // see (RULE_07)
                state_nxt = rsx_pkg::RSX_HALT; // see (RULE_08)
            end else if (wr_pend_r && addr_r == rsx_pkg::REG_CTRL) begin
                wdt_run_nxt = HWDATA[0];
            end else if (wr_pend_r && addr_r == rsx_pkg::REG_WORK) begin
                work_nxt = HWDATA[7:0];
            end else if (wr_pend_r && addr_r == rsx_pkg::REG_STATUS) begin
                carry_nxt = HWDATA[rsx_pkg::ST_CARRY_POS];
            end else if (wr_pend_r && in_file(addr_r)) begin
                file_we = 1'b1;
                file_wa = file_idx(addr_r);
                file_wd = HWDATA[7:0];
            end
        end else if (wake_s2_r) begin
            state_nxt = rsx_pkg::RSX_RUN;
        end
        // Read data for the next data phase.
        if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
            case (HADDR[7:0])
                rsx_pkg::REG_CTRL: rdata_nxt = {31'h0, wdt_run_r};
                rsx_pkg::REG_WORK: rdata_nxt = {24'h0, work_r};
                rsx_pkg::REG_STATUS: rdata_nxt = {16'h0, watchdog_counter_r, 4'h0,
                    (state_r == rsx_pkg::RSX_HALT), timeout_flag_r, power_down_flag_r, carry_r};
                default: rdata_nxt = in_file(HADDR[7:0]) ? {24'h0, file_r[file_idx(HADDR[7:0])]} : 32'h0;
            endcase
        end
    end

    // Registers; the file array is not reset, like real RAM.
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
            rdata_r <= 32'h0;
            work_r <= rsx_pkg::WORK_RESET;
            carry_r <= 1'b0;
            power_down_flag_r <= 1'b1;
            timeout_flag_r <= 1'b1;
            watchdog_counter_r <= rsx_pkg::WDT_RESET;
            presc_r <= rsx_pkg::PRESC_RESET;
            wdt_run_r <= 1'b0;
            state_r <= rsx_pkg::RSX_RUN;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
            work_r <= work_nxt;
            carry_r <= carry_nxt;
            power_down_flag_r <= power_down_flag_nxt;
            timeout_flag_r <= timeout_flag_nxt;
            watchdog_counter_r <= watchdog_counter_nxt;
            presc_r <= presc_nxt;
            wdt_run_r <= wdt_run_nxt;
            state_r <= state_nxt;
        end
        if (file_we) begin
            file_r[file_wa] <= file_wd;
        end
    end

    // Outputs straight from flops, with HREADYOUT and HRESP tied off; the slave never waits.
    always_ff @(posedge CLK) begin
        if (RST) begin
            HALTED <= 1'b0;
            OSC_RUN <= 1'b1;
        end else begin
            HALTED <= (state_nxt == rsx_pkg::RSX_HALT);
            OSC_RUN <= (state_nxt != rsx_pkg::RSX_HALT); // see (RULE_08)
        end
    end
    always_comb begin
        HRDATA = rdata_r;
        HREADYOUT = 1'b1;
        HRESP = 1'b0;
    end

    // Assertions.
    a_rot_to_work: assert property (@(posedge CLK) disable iff (RST)
        (is_rot && state_r == rsx_pkg::RSX_RUN && !instr.word[7])
        |=> work_r == {$past(file_r[faddr][6:0]), $past(carry_r)}) // see (RULE_02)
        else $error("rotate to work register wrong");
    a_rot_carry_out: assert property (@(posedge CLK) disable iff (RST)
        (is_rot && state_r == rsx_pkg::RSX_RUN) |=> carry_r == $past(file_r[faddr][7])) // see (RULE_04)
        else $error("carry not taken from bit 7");
    a_rot_file_back: assert property (@(posedge CLK) disable iff (RST)
        (is_rot && state_r == rsx_pkg::RSX_RUN && instr.word[7])
        |=> file_r[$past(faddr)] == {$past(file_r[faddr][6:0]), $past(carry_r)}) // see (RULE_03)
        else $error("rotate write back wrong");
    a_rot_keep_work: assert property (@(posedge CLK) disable iff (RST)
        (is_rot && state_r == rsx_pkg::RSX_RUN && instr.word[7]) |=> $stable(work_r)) // see (RULE_03)
        else $error("work register changed on file rotate");
    a_rot_keep_file: assert property (@(posedge CLK) disable iff (RST)
        (is_rot && state_r == rsx_pkg::RSX_RUN && !instr.word[7])
        |=> file_r[$past(faddr)] == $past(file_r[faddr])) // see (RULE_02)
        else $error("file register changed on work rotate");
    a_halt_pd_clr: assert property (@(posedge CLK) disable iff (RST)
        (is_halt && state_r == rsx_pkg::RSX_RUN) |=> !power_down_flag_r) // see (RULE_05)
        else $error("power-down flag not cleared");
    a_halt_to_set: assert property (@(posedge CLK) disable iff (RST)
        (is_halt && state_r == rsx_pkg::RSX_RUN) |=> timeout_flag_r) // see (RULE_06)
        else $error("time-out flag not set");
    a_halt_wdt_clr: assert property (@(posedge CLK) disable iff (RST)
        (is_halt && state_r == rsx_pkg::RSX_RUN) |=> watchdog_counter_r == 8'h00 && presc_r == 8'h00) // see (RULE_07)
        else $error("watchdog not cleared");
    a_halt_osc_off: assert property (@(posedge CLK) disable iff (RST)
        (is_halt && state_r == rsx_pkg::RSX_RUN) |=> HALTED && !OSC_RUN) // see (RULE_08)
        else $error("oscillator still running after halt");
    a_halt_no_exec: assert property (@(posedge CLK) disable iff (RST)
        (state_r == rsx_pkg::RSX_HALT && is_rot) |=> $stable(work_r) && $stable(carry_r)) // see (RULE_08)
        else $error("instruction executed while halted");

endmodule

`default_nettype wire

//--- tb/test_rotate_and_sleep_execution.sv
`timescale 1ns/1ps
`default_nettype none

module test_rotate_and_sleep_execution;
    // Stimulus and observed signals of the core.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic wake = 1'b0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic halted;
    logic osc_run;
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h2237;
    logic [63:0] notes [$];
    logic rd_dph = 1'b0;
    localparam logic [31:0] A_CT = {24'h0, rsx_pkg::REG_CTRL};
    localparam logic [31:0] A_IN = {24'h0, rsx_pkg::REG_INSTR};
    localparam logic [31:0] A_WK = {24'h0, rsx_pkg::REG_WORK};
    localparam logic [31:0] A_ST = {24'h0, rsx_pkg::REG_STATUS};
    localparam logic [31:0] A_FILE = {24'h0, rsx_pkg::REG_FILE_BASE};

    // Free-running 40 MHz clock; the single slave's ready is the bus ready.
    always #12.5 clk = ~clk;
    assign hready = hreadyout;

    rsx_core u_dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .WAKE(wake), .HALTED(halted), .OSC_RUN(osc_run));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Masked compare; an unknown bit never matches.
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] m);
        tests_run++;
        if ((got & m) !== exp) begin
            n_fail++;
            $display("wrong value at %0t exp %h got %h", $time, exp, got & m);
        end
    endtask

    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounded wait for ready; running out of cycles ends the run as a failure.
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            final_report();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask

    // The expected value is noted before the read goes out, so the monitor finds it in time.
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({e, m});
        bus(1'b0, a, 32'h0);
    endtask

    // Read data is taken at the edge that ends a read data phase and matched against the oldest note.
    always @(posedge clk) begin
        logic [63:0] n;
        if (rd_dph && hreadyout === 1'b1) begin
            n = notes.pop_front();
            chk(n[63:32], hrdata, n[31:0]);
            chk(32'h0, {31'h0, hresp}, 32'h1);
        end
        rd_dph <= hsel && htrans[1] && !hwrite && hready;
    end

    initial begin
        logic [7:0] v;
        logic [7:0] r;
        logic [7:0] w;
        logic [31:0] fa;
        logic c;
        logic d;
        int k;
        w = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(A_ST, 32'h0000_0006, 32'h0000_ff0f);
        rd(A_WK, 32'h0, 32'hff);
        rd(32'h40, 32'h0, 32'hffff_ffff);
        $display("test reset values done");
        // Alternate destinations; the first two hit the lowest and highest file register.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = seed[7:0];
            c = seed[8];
            d = i[0];
            fa = A_FILE + {25'h0, (i < 2) ? {5{i[0]}} : seed[13:9], 2'b00};
            r = {v[6:0], c};
            bus(1'b1, fa, {24'h0, v});
            bus(1'b1, A_ST, {31'h0, c});
            bus(1'b1, A_IN, {18'h0, rsx_pkg::OP_ROTATE_LEFT | (14'(d) << rsx_pkg::DEST_BIT_POS) | 14'(fa[6:2])});
            if (d) begin
                rd(fa, {24'h0, r}, 32'hff);
                rd(A_WK, {24'h0, w}, 32'hff);
            end else begin
                w = r;
                rd(A_WK, {24'h0, r}, 32'hff);
                rd(fa, {24'h0, v}, 32'hff);
            end
            rd(A_ST, {31'h0, v[7]}, 32'h1);
        end
        $display("test rotate done");
        // Let the watchdog advance past a prescaler wrap so that clearing it is visible.
        bus(1'b1, A_CT, 32'h1);
        repeat (600) @(posedge clk);
        rd(A_ST, 32'h0000_0200, 32'h0000_ff00);
        bus(1'b1, A_IN, {18'h0, rsx_pkg::OP_HALT});
        @(posedge clk);
        chk(32'h1, {31'h0, halted}, 32'h1);
        chk(32'h0, {31'h0, osc_run}, 32'h1);
        rd(A_ST, 32'h0000_000c, 32'h0000_ff0e);
        bus(1'b1, A_IN, {18'h0, rsx_pkg::OP_ROTATE_LEFT | 14'h0001});
        bus(1'b1, A_WK, 32'h5a);
        rd(A_WK, {24'h0, w}, 32'hff);
        wake <= 1'b1;
        k = 0;
        while (halted !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        wake <= 1'b0;
        if (halted !== 1'b0) begin
            n_fail++;
            final_report();
        end
        chk(32'h1, {31'h0, osc_run}, 32'h1);
        $display("test halt and wake done");
        repeat (2) @(posedge clk);
        chk(32'h0, notes.size(), 32'hffff_ffff);
        final_report();
    end
endmodule

`default_nettype wire
